// ===== rplc_regs.svh
/*
 Register offsets, field positions, reset values and timing figures of the
 front-panel lamp controller. Assumes a 4 ns system clock and byte addresses
 on an AHB-Lite bus with one aligned 32-bit word per register.
*/
`ifndef RPLC_REGS_SVH
`define RPLC_REGS_SVH

// ==========================================================================
// Register byte offsets (low address byte only)
`define RPLC_ADDR_PHASE 8'h00
`define RPLC_ADDR_STATE 8'h04
`define RPLC_ADDR_EVENT 8'h08
`define RPLC_ADDR_IRQ_STAT 8'h0C
`define RPLC_ADDR_IRQ_MASK 8'h10
`define RPLC_ADDR_LAMPS 8'h14

// ==========================================================================
// Phase register fields
`define RPLC_PH_LO 0
`define RPLC_PH_HI 1
`define RPLC_PH_CHECK 4
`define RPLC_PH_FDR 5

// ==========================================================================
// System state register fields
`define RPLC_ST_MEM_TEST 0
`define RPLC_ST_ISDN_TEST 1
`define RPLC_ST_LAN_TEST 2
`define RPLC_ST_TEST_FAIL 3
`define RPLC_ST_LDR_ACTIVE 4
`define RPLC_ST_LDR_PACK 5
`define RPLC_ST_FDR_READY 6
`define RPLC_ST_LDR_ERR 7
`define RPLC_ST_DSL_UP 8
`define RPLC_ST_DSL_TRAFFIC 9
`define RPLC_ST_ISDN_L1 10
`define RPLC_ST_BCH_LO 11
`define RPLC_ST_BCH_HI 12
`define RPLC_ST_LAN_LINK 13
`define RPLC_ST_LAN_TRAFFIC 14
`define RPLC_ST_RESTART 15
`define RPLC_ST_WIDTH 16

// ==========================================================================
// Event register bits (write one to fire) and interrupt bits
`define RPLC_EV_LAN_ERR 0
`define RPLC_EV_FDR_DONE 1
`define RPLC_IRQ_CHECK 0
`define RPLC_IRQ_FDR 1
`define RPLC_IRQ_LAN_ERR 2
`define RPLC_IRQ_WIDTH 3

// ==========================================================================
// Reset values and timing
`define RPLC_STATE_RST 16'h0000
`define RPLC_MASK_RST 3'h0
`define RPLC_FDR_STEPS 3'h6
`define RPLC_CLK_NS 4
`define RPLC_LAMP_CHECK_MS 500
`define RPLC_BLINK_HALF_MS 250
`define RPLC_ERR_PULSE_MS 100
`define RPLC_NS_PER_MS 1000000

`endif

// ===== rplc_pkg.sv
/*
 Types shared by the lamp controller files. Assumes nothing of its
 surroundings.
*/
`default_nettype none

// ==========================================================================
// Operating phases
package rplc_pkg;
   typedef enum logic [1:0] {PH_START, PH_LOADER, PH_NORMAL} rplc_phase_e;
endpackage : rplc_pkg

`default_nettype wire

// ===== rplc_blink.sv
/*
 Free-running blink time base: a square wave with a fixed half period and a
 one-cycle pulse at each change. Assumes a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rplc_blink #(
   parameter int unsigned HALF_CYC = 32'd62500000
) (
   input wire logic mclk,     // System clock
   input wire logic sys_rst,  // Synchronous reset
   output var logic blink,    // Blink level
   output var logic toggle    // Pulse when blink changes
);
   logic [31:0] cnt;

   // ==========================================================================
   // Half-period counter; every blinking lamp shares it so blinking lamps stay in step
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cnt <= 32'h0;
         blink <= 1'b0;
         toggle <= 1'b0;
      end
      else if (cnt == HALF_CYC - 32'h1)
      begin
         cnt <= 32'h0;
         blink <= ~blink;
         toggle <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 32'h1;
         toggle <= 1'b0;
      end
   end
endmodule : rplc_blink

`default_nettype wire

// ===== rplc_top.sv
/*
 Front-panel lamp controller: an AHB-Lite register slave, the lamp check,
 phase-dependent lamp decoding, blink, error pulse and three-blink timing.
 Assumes one 250 MHz clock and that software keeps the state register current.
*/
// Our own choices: register access over AHB-Lite and the address map.
// Summary of operation
// - All lamps lit half second after reset
// - Phase selects what lamps mean
// - Line lamps: green, orange, or both yellow
// - Start: memory, ISDN, LAN test lamps
// - Test lamp lit only while test runs
// - Test failure lights error with test lamp
// - Loader active: ISDN steady yellow, SHDSL dark
// - Loader compressing: ISDN blinks yellow
// - Reset-ready: both yellow, link, activity steady
// - Reset done: four lamps blink three times
// - Loader error lights error lamp
// - SHDSL green when up, orange blinks traffic
// - ISDN green layer1, orange per channel count
// - Link lamp link up, activity blinks traffic
// - LAN error pulses error lamp
// - Restart lights error lamp permanently
`timescale 1ns/1ps
`default_nettype none
`include "rplc_regs.svh"

module rplc_top #(
   parameter int unsigned LAMP_CHECK_CYC =
      `RPLC_LAMP_CHECK_MS * `RPLC_NS_PER_MS / `RPLC_CLK_NS,
   parameter int unsigned BLINK_HALF_CYC =
      `RPLC_BLINK_HALF_MS * `RPLC_NS_PER_MS / `RPLC_CLK_NS,
   parameter int unsigned ERR_PULSE_CYC =
      `RPLC_ERR_PULSE_MS * `RPLC_NS_PER_MS / `RPLC_CLK_NS
) (
   input wire logic mclk,            // System clock
   input wire logic sys_rst,         // Synchronous reset
   input wire logic hsel,            // Slave select
   input wire logic [31:0] haddr,    // Byte address
   input wire logic [1:0] htrans,    // Transfer type
   input wire logic hwrite,          // Write when high
   input wire logic [2:0] hsize,     // Transfer size
   input wire logic [31:0] hwdata,   // Write data
   input wire logic hready,          // Bus ready
   output var logic hreadyout,       // Slave ready
   output var logic hresp,           // Response, always OKAY
   output var logic [31:0] hrdata,   // Read data
   output var logic irq,             // Level interrupt
   output var logic power_lamp,      // Power lamp
   output var logic err_lamp,        // Error lamp
   output var logic link_lamp,       // LAN link lamp
   output var logic activity_lamp,   // LAN activity lamp
   output var logic isdn_green,      // ISDN lamp green
   output var logic isdn_orange,     // ISDN lamp orange
   output var logic dsl_green,       // SHDSL lamp green
   output var logic dsl_orange       // SHDSL lamp orange
);
   rplc_pkg::rplc_phase_e loader_mode_ph;
   logic [`RPLC_ST_WIDTH-1:0] state;
   logic [`RPLC_IRQ_WIDTH-1:0] irq_stat;
   logic [`RPLC_IRQ_WIDTH-1:0] irq_mask;
   logic [31:0] chk_cnt;
   logic check_active;
   logic [31:0] err_cnt;
   logic [2:0] fdr_cnt;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic addr_ok;
   logic rd_take;
   logic [31:0] next_rdata;
   logic ev_lan_err;
   logic ev_fdr;
   logic ev_check_done;
   logic ev_fdr_done;
   logic blink;
   logic blink_tog;
   logic [7:0] next_lamps;
   logic [7:0] lamps;
   logic [1:0] bch;

   // ==========================================================================
   // Shared blink time base
   rplc_blink #(
      .HALF_CYC(BLINK_HALF_CYC)
   ) u_blink (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .blink(blink),
      .toggle(blink_tog)
   );

   // ==========================================================================
   // Bus address phase; zero wait states so hready never drops
   assign addr_ok = hsel && htrans[1] && hready;
   assign rd_take = addr_ok && !hwrite;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Write events fire in the data phase, when hwdata stands
   assign ev_lan_err = wr_pend && wr_addr == `RPLC_ADDR_EVENT && hwdata[`RPLC_EV_LAN_ERR];
   assign ev_fdr = wr_pend && wr_addr == `RPLC_ADDR_EVENT && hwdata[`RPLC_EV_FDR_DONE];

   // ==========================================================================
   // Writable registers; unknown offsets are ignored
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         loader_mode_ph <= rplc_pkg::PH_START;
         state <= `RPLC_STATE_RST;
         irq_mask <= `RPLC_MASK_RST;
      end
      else if (wr_pend)
      begin
         if (wr_addr == `RPLC_ADDR_PHASE && hwdata[`RPLC_PH_HI:`RPLC_PH_LO] != 2'h3)
            loader_mode_ph <= rplc_pkg::rplc_phase_e'(hwdata[`RPLC_PH_HI:`RPLC_PH_LO]);
         if (wr_addr == `RPLC_ADDR_STATE)
            state <= hwdata[`RPLC_ST_WIDTH-1:0];
         if (wr_addr == `RPLC_ADDR_IRQ_MASK)
            irq_mask <= hwdata[`RPLC_IRQ_WIDTH-1:0];
      end
   end

   // ==========================================================================
   // Read data, captured in the address phase so hrdata comes from a flop.
   // A write still in its data phase is forwarded so back-to-back
   // write-then-read of the same register sees the new value.
   always_comb
   begin
      next_rdata = 32'h0;
      unique case (haddr[7:0])
         `RPLC_ADDR_PHASE:
         begin
            next_rdata[`RPLC_PH_HI:`RPLC_PH_LO] = loader_mode_ph;
            next_rdata[`RPLC_PH_CHECK] = check_active;
            next_rdata[`RPLC_PH_FDR] = fdr_cnt != 3'h0;
            if (wr_pend && wr_addr == `RPLC_ADDR_PHASE
                && hwdata[`RPLC_PH_HI:`RPLC_PH_LO] != 2'h3)
               next_rdata[`RPLC_PH_HI:`RPLC_PH_LO] = hwdata[`RPLC_PH_HI:`RPLC_PH_LO];
         end
         `RPLC_ADDR_STATE:
            next_rdata[`RPLC_ST_WIDTH-1:0] = (wr_pend && wr_addr == `RPLC_ADDR_STATE)
               ? hwdata[`RPLC_ST_WIDTH-1:0] : state;
         `RPLC_ADDR_IRQ_STAT:
            next_rdata[`RPLC_IRQ_WIDTH-1:0] = irq_stat;
         `RPLC_ADDR_IRQ_MASK:
            next_rdata[`RPLC_IRQ_WIDTH-1:0] = (wr_pend && wr_addr == `RPLC_ADDR_IRQ_MASK)
               ? hwdata[`RPLC_IRQ_WIDTH-1:0] : irq_mask;
         `RPLC_ADDR_LAMPS:
            next_rdata[7:0] = lamps;
         default:
            next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         hrdata <= 32'h0;
      else if (rd_take)
         hrdata <= next_rdata;
   end

   // ==========================================================================
   // Lamp check after reset
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         chk_cnt <= 32'h0;
         check_active <= 1'b1;
      end
      else if (check_active)
      begin
         chk_cnt <= chk_cnt + 32'h1;
         if (chk_cnt == LAMP_CHECK_CYC - 32'h1)
            check_active <= 1'b0;
      end
   end
   assign ev_check_done = check_active && chk_cnt == LAMP_CHECK_CYC - 32'h1;

   // ==========================================================================
   // Three-blink sequence: six half periods of the shared time base,
   // lamps lit on even steps. The first step may be short since the base
   // runs free; the trade buys one counter for all blinking.
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         fdr_cnt <= 3'h0;
      else if (ev_fdr && loader_mode_ph == rplc_pkg::PH_LOADER)
         fdr_cnt <= `RPLC_FDR_STEPS;
      else if (loader_mode_ph != rplc_pkg::PH_LOADER)
         fdr_cnt <= 3'h0;
      else if (blink_tog && fdr_cnt != 3'h0)
         fdr_cnt <= fdr_cnt - 3'h1;
   end
   assign ev_fdr_done = blink_tog && fdr_cnt == 3'h1;

   // ==========================================================================
   // Error pulse: each LAN error event restarts a fixed pulse
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         err_cnt <= 32'h0;
      else if (ev_lan_err)
         err_cnt <= ERR_PULSE_CYC;
      else if (err_cnt != 32'h0)
         err_cnt <= err_cnt - 32'h1;
   end

   // ==========================================================================
   // Sticky interrupt status; a new event wins over the read that clears it
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         irq_stat <= 3'h0;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat <= (rd_take && haddr[7:0] == `RPLC_ADDR_IRQ_STAT ? 3'h0 : irq_stat)
            | {ev_lan_err, ev_fdr_done, ev_check_done};
         irq <= |(irq_stat & irq_mask);
      end
   end

   // ==========================================================================
   // Lamp decode; bit order: power, err, link, activity, isdn g/o, dsl g/o
   assign bch = state[`RPLC_ST_BCH_HI:`RPLC_ST_BCH_LO];

   always_comb
   begin
      next_lamps = 8'h80;
      if (check_active)
         next_lamps = 8'hFF;
      else
      begin
         unique case (loader_mode_ph)
            rplc_pkg::PH_START:
            begin
               next_lamps[3] = state[`RPLC_ST_MEM_TEST];
               next_lamps[2] = state[`RPLC_ST_ISDN_TEST];
               next_lamps[4] = state[`RPLC_ST_LAN_TEST];
               next_lamps[6] = state[`RPLC_ST_TEST_FAIL];
            end
            rplc_pkg::PH_LOADER:
            begin
               next_lamps[5] = state[`RPLC_ST_LAN_LINK];
               next_lamps[4] = state[`RPLC_ST_LAN_TRAFFIC];
               next_lamps[6] = state[`RPLC_ST_LDR_ERR];
               if (fdr_cnt != 3'h0)
               begin
                  next_lamps[5:0] = {6{~fdr_cnt[0]}};
               end
               else if (state[`RPLC_ST_FDR_READY])
                  next_lamps[5:0] = 6'h3F;
               else if (state[`RPLC_ST_LDR_PACK])
                  next_lamps[3:2] = {2{blink}};
               else if (state[`RPLC_ST_LDR_ACTIVE])
                  next_lamps[3:2] = 2'h3;
            end
            rplc_pkg::PH_NORMAL:
            begin
               next_lamps[1] = state[`RPLC_ST_DSL_UP];
               next_lamps[0] = state[`RPLC_ST_DSL_TRAFFIC] && blink;
               next_lamps[3] = state[`RPLC_ST_ISDN_L1];
               next_lamps[2] = bch == 2'h1 || (bch[1] && blink);
               next_lamps[5] = state[`RPLC_ST_LAN_LINK];
               next_lamps[4] = state[`RPLC_ST_LAN_TRAFFIC] && blink;
               next_lamps[6] = state[`RPLC_ST_RESTART]
                  || err_cnt != 32'h0;
            end
            default:
               next_lamps = 8'h80;
         endcase
      end
   end

   // Line lamps take their two colours independently, so both makes yellow
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         lamps <= 8'h00;
      else
         lamps <= next_lamps;
   end
   assign {power_lamp, err_lamp, link_lamp, activity_lamp} = lamps[7:4];
   assign {isdn_green, isdn_orange, dsl_green, dsl_orange} = lamps[3:0];

   // ==========================================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_check_all_lit: assert property (check_active |=> lamps == 8'hFF)
      else $error("lamp check not lighting all lamps");
   a_check_length: assert property ($fell(check_active)
      |-> $past(chk_cnt) == LAMP_CHECK_CYC - 32'h1)
      else $error("lamp check length wrong");
   a_start_tests: assert property (!check_active && loader_mode_ph == rplc_pkg::PH_START
      |=> isdn_green == $past(state[`RPLC_ST_MEM_TEST]) && !dsl_green && !dsl_orange
      && activity_lamp == $past(state[`RPLC_ST_LAN_TEST]) && !link_lamp)
      else $error("start test lamps wrong");
   a_start_error: assert property (!check_active && loader_mode_ph == rplc_pkg::PH_START
      |=> err_lamp == $past(state[`RPLC_ST_TEST_FAIL]))
      else $error("start error lamp wrong");
   a_fdr_ready: assert property (!check_active && loader_mode_ph == rplc_pkg::PH_LOADER
      && fdr_cnt == 3'h0 && state[`RPLC_ST_FDR_READY] |=> lamps[5:0] == 6'h3F)
      else $error("reset-ready lamps wrong");
   a_fdr_start: assert property (ev_fdr && loader_mode_ph == rplc_pkg::PH_LOADER
      |=> fdr_cnt == 3'h6)
      else $error("three-blink sequence not started");
   a_yellow_pair: assert property (!check_active && loader_mode_ph == rplc_pkg::PH_LOADER
      |=> isdn_green == isdn_orange)
      else $error("loader ISDN lamp not yellow");
   a_one_channel: assert property (!check_active && loader_mode_ph == rplc_pkg::PH_NORMAL
      && bch == 2'h1 |=> isdn_orange)
      else $error("one channel lamp wrong");
   // Two cycles of restart are needed, since each lamp follows its state one cycle late
   a_restart_err: assert property ((!check_active && loader_mode_ph == rplc_pkg::PH_NORMAL
      && state[`RPLC_ST_RESTART]) [*2] |-> err_lamp [*2])
      else $error("restart error lamp wrong");
   a_err_pulse: assert property (ev_lan_err |=> err_cnt == ERR_PULSE_CYC)
      else $error("error pulse not loaded");

   c_check_done: cover property ($fell(check_active));
   c_fdr_done: cover property (ev_fdr_done);
   c_two_channels: cover property (loader_mode_ph == rplc_pkg::PH_NORMAL && bch == 2'h2);
   c_irq: cover property ($rose(irq));
endmodule : rplc_top

`default_nettype wire

// ===== rplc_panel.sv
/*
 Front-panel model: watches the SHDSL lamp and counts its yellow flashes.
 Assumes active-high lamp levels that change only on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Lamp panel observer
module rplc_panel (
   input wire logic mclk,        // System clock
   input wire logic clr,         // Clear the flash count
   input wire logic dsl_green,   // SHDSL green colour
   input wire logic dsl_orange,  // SHDSL orange colour
   output var int flashes        // Yellow flashes seen
);
   logic was_on;

   // One colour alone is not yellow, so only both together count
   always_ff @(posedge mclk)
   begin
      was_on <= dsl_green & dsl_orange;
      if (clr)
         flashes <= 0;
      else if (dsl_green && dsl_orange && !was_on)
         flashes <= flashes + 1;
   end
endmodule : rplc_panel

`default_nettype wire

// ===== testbench.sv
/*
 Self-checking bench of the lamp controller: AHB-Lite master tasks, a lamp
 model per phase and the panel observer. Assumes short timing parameters.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bench top
module testbench;
   localparam int LCK = 20;
   localparam int HALF = 4;
   localparam int PULSE = 6;
   logic mclk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, clr = 1'h1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hready, hreadyout, hresp, irq, power_lamp, err_lamp, link_lamp;
   logic activity_lamp, isdn_green, isdn_orange, dsl_green, dsl_orange;
   logic [7:0] lamps;
   logic [15:0] st, e;
   logic [15:0] msk [3] = '{16'h000F, 16'h6080, 16'hFF00};
   int n_fail = 0, samples_checked = 0, flashes, k, q, ph;

   assign hready = hreadyout;
   assign lamps = {power_lamp, err_lamp, link_lamp, activity_lamp,
                   isdn_green, isdn_orange, dsl_green, dsl_orange};

   // Clock of 4 ns
   always #2 mclk = ~mclk;

   rplc_top #(.LAMP_CHECK_CYC(LCK), .BLINK_HALF_CYC(HALF), .ERR_PULSE_CYC(PULSE))
      rplc_top_inst (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq, .power_lamp,
      .err_lamp, .link_lamp, .activity_lamp, .isdn_green, .isdn_orange,
      .dsl_green, .dsl_orange);

   rplc_panel rplc_panel_inst (.mclk, .clr, .dsl_green, .dsl_orange, .flashes);

   // ==========================================================================
   // Reporting
   task automatic summarize;
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // ==========================================================================
   // Bus master: called just after a rising edge; select stays up between
   // transfers, so back-to-back calls drive only htrans twice in one time step, the later value winning
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      for (int p = 0; p < 2; p++)
      begin
         n = 0;
         do
         begin
            @(posedge mclk);
            n++;
         end while (hreadyout !== 1'h1 && n < 20);
         if (n >= 20)
         begin
            n_fail++;
            summarize();
         end
         htrans <= 2'h0;
         hwdata <= wd;
      end
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask : bus

   // ==========================================================================
   // Lamp model: steady value in the upper byte, blinking lamps below
   function automatic logic [15:0] model(input int p, input logic [15:0] s);
      logic [7:0] v, b;
      b = 8'h00;
      if (p == 0)
         v = {1'h1, s[3], 1'h0, s[2], s[0], s[1], 2'h0};
      else if (p == 1)
      begin
         v = {1'h1, s[7], s[13], s[14], s[4], s[4], 2'h0};
         if (s[6])
            v = {1'h1, s[7], 6'h3F};
         else if (s[5])
            b = 8'h0C;
      end
      else
      begin
         v = {1'h1, s[15], s[13], 1'h0, s[10], s[12:11] == 2'h1, s[8], 1'h0};
         b = {3'h0, s[14], 1'h0, s[12], 1'h0, s[9]};
      end
      return {v, b};
   endfunction : model

   // Samples at falling edges, so no race with the launching edge
   task automatic observe(input logic [7:0] v, input logic [7:0] bm);
      int ch [8];
      logic [7:0] prev;
      ch = '{default: 0};
      @(negedge mclk);
      prev = lamps;
      repeat (4 * HALF)
      begin
         @(negedge mclk);
         for (int i = 0; i < 8; i++)
            ch[i] += int'(lamps[i] !== prev[i]);
         prev = lamps;
         check("steady lamps", {24'h0, lamps & ~bm}, {24'h0, v & ~bm});
         if (bm[3] & bm[2])
            check("yellow pair", {31'h0, lamps[3]}, {31'h0, lamps[2]});
      end
      for (int i = 0; i < 8; i++)
         if (bm[i])
            check("blink changes", ch[i] >= 2, 1);
      @(posedge mclk);
   endtask : observe

   // ==========================================================================
   // Main sequence
   initial
   begin
      void'($urandom(32'h9E5B));
      repeat (12) @(posedge mclk);
      sys_rst <= 1'h0;
      k = 0;
      repeat (LCK + 8)
      begin
         @(negedge mclk);
         k += int'(lamps === 8'hFF);
      end
      check("lamp check cycles", k, LCK);
      @(posedge mclk);
      bus(1'h0, 8'h00, 0);
      check("phase", rd, 32'h0);
      bus(1'h0, 8'h0C, 0);
      check("irq stat", rd, 32'h1);
      bus(1'h0, 8'h0C, 0);
      check("irq stat cleared", rd, 32'h0);
      bus(1'h1, 8'h10, 32'hFFFFFFFF);
      bus(1'h0, 8'h10, 0);
      check("irq mask", rd, 32'h7);
      bus(1'h0, 8'h20, 0);
      check("unmapped", rd, 32'h0);
      bus(1'h1, 8'h14, 32'hFFFFFFFF);
      bus(1'h0, 8'h14, 0);
      check("lamps reg", rd, 32'h80);
      bus(1'h0, 8'h08, 0);
      check("event reg", rd, 32'h0);
      // Phases start, normal, loader with random state
      for (int i = 0; i < 3; i++)
      begin
         ph = (i == 0) ? 0 : 3 - i;
         bus(1'h1, 8'h00, ph);
         for (int j = 0; j < 6; j++)
         begin
            st = ($urandom & msk[ph]) | ((ph == 1) ? (16'h0010 << (j % 3)) : 16'h0);
            bus(1'h1, 8'h04, {16'h0, st});
            e = model(ph, st);
            repeat (2) @(posedge mclk);
            observe(e[15:8], e[7:0]);
         end
      end
      // Factory reset done: three flashes together
      bus(1'h1, 8'h04, 0);
      clr <= 1'h0;
      bus(1'h1, 8'h08, 32'h2);
      bus(1'h0, 8'h00, 0);
      check("phase blink busy", rd, 32'h21);
      repeat (8 * HALF)
      begin
         @(negedge mclk);
         check("blink group", lamps[5:0] == 6'h0 || lamps[5:0] == 6'h3F, 1);
      end
      check("flash count", flashes, 3);
      @(posedge mclk);
      bus(1'h0, 8'h0C, 0);
      check("irq stat blink", rd, 32'h2);
      // Normal: LAN error pulse and interrupt
      bus(1'h1, 8'h00, 32'h2);
      bus(1'h1, 8'h10, 32'h4);
      bus(1'h1, 8'h08, 32'h1);
      k = 0;
      q = 0;
      repeat (PULSE + 6)
      begin
         @(negedge mclk);
         k += int'(err_lamp === 1'h1);
         q += int'(irq === 1'h1);
      end
      check("err pulse", k, PULSE);
      check("irq raised", q, PULSE + 5);
      @(posedge mclk);
      bus(1'h0, 8'h0C, 0);
      check("irq stat lan", rd, 32'h4);
      repeat (2) @(negedge mclk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      @(posedge mclk);
      bus(1'h1, 8'h10, 0);
      bus(1'h1, 8'h08, 32'h1);
      repeat (3) @(negedge mclk);
      check("irq masked", {31'h0, irq}, 32'h0);
      @(posedge mclk);
      bus(1'h0, 8'h0C, 0);
      check("irq stat masked", rd, 32'h4);
      summarize();
   end
endmodule : testbench

`default_nettype wire
